//--- rmcfg_latch.sv
/*
  Model of the external configuration latch at the far side of the loader.
  Assumes the bench supplies the wanted pin word and the loader's reset output.
*/
`timescale 1ns/1ps
module rmcfg_latch (
  // Clock and gate
  input  wire logic        pclk,
  input  wire logic        reset_output_n,
  input  wire logic [34:0] want,
  // Configuration pins
  output logic             config_enable_n,
  output logic             clock_source_sel_hi,
  output logic             clock_source_sel_lo,
  output logic [31:0]      data_in
);
  logic [34:0] pins_r;
  // Latch drives wanted levels
  // Once released the bus carries traffic, so the pins flip every cycle
  always_ff @(posedge pclk) begin
    pins_r <= reset_output_n ? ~pins_r : want;
  end
  // Pin fan-out
  assign {config_enable_n, clock_source_sel_hi, clock_source_sel_lo, data_in} = pins_r;
endmodule

//--- rmcfg_pkg.sv
/*
  Package for the reset-time configuration loader: field positions on the
  data bus, encodings of the captured modes, defaults and register map.
  Assumes a 32-bit data bus and a 32-bit APB slave port.
*/
package rmcfg_pkg;

  // Data-bus bit positions sampled at reset
  localparam int unsigned BIT_MODE2  = 26;
  localparam int unsigned BIT_MODE1  = 17;
  localparam int unsigned BIT_MODE0  = 16;
  localparam int unsigned BIT_SPLIT1 = 25;
  localparam int unsigned BIT_SPLIT0 = 24;
  localparam int unsigned BIT_DRIVE  = 21;
  localparam int unsigned BIT_PORT1  = 20;
  localparam int unsigned BIT_PORT0  = 19;

  // Operating mode code for master
  localparam logic [2:0] MODE_MASTER = 3'h7;

  // Boot port width
  typedef enum logic [1:0] {
    RMCFG_PORT_32 = 2'h0,
    RMCFG_PORT_8  = 2'h1,
    RMCFG_PORT_16 = 2'h2
  } rmcfg_port_t;

  // Clock source
  typedef enum logic [1:0] {
    RMCFG_CLK_EXT     = 2'h0,
    RMCFG_CLK_PLL_1TO1 = 2'h1,
    RMCFG_CLK_PLL_EXT = 2'h2,
    RMCFG_CLK_PLL_XTAL = 2'h3
  } rmcfg_clk_t;

  // Captured settings
  typedef struct packed {
    logic        master;      // 1: master mode, 0: reserved code seen
    logic [2:0]  mode_raw;
    rmcfg_port_t port;
    logic        full_drive;
    rmcfg_clk_t  clk;
    logic [1:0]  cs_count;    // Number of upper address pins used as chip selects
    logic        from_pins;   // 1: settings came from the pins
  } rmcfg_cfg_t;

  // Defaults when configuration is disabled
  localparam rmcfg_cfg_t CFG_DEFAULT = '{
    master: 1'b1, mode_raw: MODE_MASTER, port: RMCFG_PORT_32, full_drive: 1'b0,
    clk: RMCFG_CLK_PLL_XTAL, cs_count: 2'h0, from_pins: 1'b0};

  // APB register map (byte addresses)
  localparam logic [11:0] ADDR_CFG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;

  // Cycles the reset output stays low after presetn release
  localparam int unsigned RST_OUT_HOLD_CYCLES = 4;

  // Whole module state
  typedef struct packed {
    rmcfg_cfg_t  cfg;
    logic        captured;
    logic [2:0]  cnt;
    logic        rst_out_n;
    logic        bus_cfg;     // Data bus held for configuration
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } rmcfg_state_t;

endpackage

//--- rmcfg_top.sv
/*
  Reset-time configuration loader. Samples the configuration pins while
  reset is in effect, holds the result afterwards, and shows it over APB.
  Assumes an external latch, gated by reset_output_n, drives the pins.
*/
`timescale 1ns/1ps

// How it works
// - Capture only during reset, then hold
// - Enable low: settings come from pins
// - Enable high: fixed defaults used
// - Mode 111 is master, others reserved
// - Port bits select boot port width
// - One bit selects pad drive strength
// - Clock pins select clock source
// - Split bits assign upper address pins
module rmcfg_top
  import rmcfg_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration pins
  input  wire logic        config_enable_n,
  input  wire logic        clock_source_sel_hi,
  input  wire logic        clock_source_sel_lo,
  input  wire logic [31:0] data_in,
  // Reset output and captured settings
  output logic             reset_output_n,
  output logic             data_bus_cfg,
  output rmcfg_cfg_t       cfg,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr
);

  rmcfg_state_t st_r;
  rmcfg_state_t st_nxt;
  rmcfg_cfg_t   pin_cfg;

  // Decode of the pins into settings
  always_comb begin
    pin_cfg = CFG_DEFAULT;
    pin_cfg.from_pins = 1'b1;
    pin_cfg.mode_raw = {data_in[BIT_MODE2], data_in[BIT_MODE1], data_in[BIT_MODE0]};
    pin_cfg.master   = (pin_cfg.mode_raw == MODE_MASTER);
    unique case ({data_in[BIT_PORT1], data_in[BIT_PORT0]})
      2'h2:    pin_cfg.port = RMCFG_PORT_8;
      2'h1:    pin_cfg.port = RMCFG_PORT_16;
      default: pin_cfg.port = RMCFG_PORT_32;
    endcase
    pin_cfg.full_drive = data_in[BIT_DRIVE];
    pin_cfg.clk = rmcfg_clk_t'({clock_source_sel_hi, clock_source_sel_lo});
    unique case ({data_in[BIT_SPLIT1], data_in[BIT_SPLIT0]})
      2'h2:    pin_cfg.cs_count = 2'h1;
      2'h1:    pin_cfg.cs_count = 2'h2;
      2'h3:    pin_cfg.cs_count = 2'h3;
      default: pin_cfg.cs_count = 2'h0;
    endcase
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    // Reset output held low a few cycles after release, capture meanwhile
    if (!st_r.captured) begin
      st_nxt.cfg = config_enable_n ? CFG_DEFAULT : pin_cfg;
      if (st_r.cnt == 3'(RST_OUT_HOLD_CYCLES - 1)) begin
        st_nxt.captured  = 1'b1;
        st_nxt.rst_out_n = 1'b1;
        st_nxt.bus_cfg   = 1'b0;
      end else begin
        st_nxt.cnt = st_r.cnt + 3'h1;
      end
    end
    // APB: one wait-free access phase answer
    st_nxt.pready  = psel && !penable;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata  = 32'h0000_0000;
    if (psel && !penable) begin
      unique case (paddr)
        ADDR_CFG: begin
          st_nxt.prdata = 32'(st_r.cfg);
          st_nxt.pslverr = pwrite;  // Read only
        end
        ADDR_STATUS: begin
          st_nxt.prdata = {29'h0, st_r.bus_cfg, st_r.rst_out_n, st_r.captured};
          st_nxt.pslverr = pwrite;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r           <= '0;
      st_r.cfg       <= CFG_DEFAULT;
      st_r.bus_cfg   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign reset_output_n = st_r.rst_out_n;
  assign data_bus_cfg   = st_r.bus_cfg;
  assign cfg            = st_r.cfg;
  assign pready         = st_r.pready;
  assign prdata         = st_r.prdata;
  assign pslverr        = st_r.pslverr;

  // Capture window length, as a local constant for the delay ranges below
  localparam int WIN_CYC = RST_OUT_HOLD_CYCLES;

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      st_r.captured |=> $stable(st_r.cfg);
  endproperty
  a_hold: assert property (p_hold) else $error("settings changed after capture");

  property p_window;
    @(posedge pclk) disable iff (!presetn)
      $rose(presetn) |-> !reset_output_n ##[WIN_CYC:WIN_CYC] reset_output_n;
  endproperty
  a_window: assert property (p_window) else $error("capture window length wrong");

  property p_defaults;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && config_enable_n) |=> (st_r.cfg == CFG_DEFAULT);
  endproperty
  a_defaults: assert property (p_defaults) else $error("defaults not taken");

  property p_pins;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n) |=> st_r.cfg.from_pins;
  endproperty
  a_pins: assert property (p_pins) else $error("pins not used");

  property p_master;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n)
        |=> st_r.cfg.master == ($past({data_in[BIT_MODE2], data_in[BIT_MODE1],
                                         data_in[BIT_MODE0]}) == MODE_MASTER);
  endproperty
  a_master: assert property (p_master) else $error("mode decode wrong");

  // Port code 10 gives 8 bits
  property p_port8;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n && data_in[BIT_PORT1] && !data_in[BIT_PORT0])
        |=> st_r.cfg.port == RMCFG_PORT_8;
  endproperty
  a_port8: assert property (p_port8) else $error("port width wrong");

  // Port code 01 gives 16 bits
  property p_port16;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n && !data_in[BIT_PORT1] && data_in[BIT_PORT0])
        |=> st_r.cfg.port == RMCFG_PORT_16;
  endproperty
  a_port16: assert property (p_port16) else $error("16-bit port width wrong");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n) |=> st_r.cfg.full_drive == $past(data_in[BIT_DRIVE]);
  endproperty
  a_drive: assert property (p_drive) else $error("drive bit wrong");

  property p_clk;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n)
        |=> st_r.cfg.clk == $past({clock_source_sel_hi, clock_source_sel_lo});
  endproperty
  a_clk: assert property (p_clk) else $error("clock source wrong");

  // Split code 10 gives one select
  property p_split;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n && data_in[BIT_SPLIT1] && !data_in[BIT_SPLIT0])
        |=> st_r.cfg.cs_count == 2'h1;
  endproperty
  a_split: assert property (p_split) else $error("pin split wrong");

  // Split code 11 gives three selects
  property p_split3;
    @(posedge pclk) disable iff (!presetn)
      (!st_r.captured && !config_enable_n && data_in[BIT_SPLIT1] && data_in[BIT_SPLIT0])
        |=> st_r.cfg.cs_count == 2'h3;
  endproperty
  a_split3: assert property (p_split3) else $error("three-select split wrong");

  property p_release;
    @(posedge pclk) disable iff (!presetn)
      $rose(reset_output_n) |-> !data_bus_cfg ##1 !data_bus_cfg;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  c_pins: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.captured) && st_r.cfg.from_pins);
  c_default: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.captured) && !st_r.cfg.from_pins);
  c_read: cover property (@(posedge pclk) disable iff (!presetn) pready && !pslverr);
  c_reserved: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r.captured) && st_r.cfg.from_pins && !st_r.cfg.master);

endmodule

//--- rmcfg_top_test.sv
/*
  Self-checking bench for the reset-time configuration loader.
  Assumes the latch model drives the pins and the APB port reads them back.
*/
`timescale 1ns/1ps
module rmcfg_top_test;
  import rmcfg_pkg::*;
  // Bench signals
  logic        pclk    = 1'h0;
  logic        presetn = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [11:0] paddr   = 12'h0;
  logic [31:0] pwdata  = 32'h0;
  logic [34:0] want    = 35'h0;
  logic [31:0] prdata, rd, din;
  logic        en_n, ck_hi, ck_lo, rst_n, bus_cfg, pready, pslverr, err;
  rmcfg_cfg_t  cfg, exp;
  int          num_errors = 0;
  int          cmp_count = 0;

  // Clock
  always #5 pclk = ~pclk;

  // Far side and design
  rmcfg_latch i_latch (.pclk(pclk), .reset_output_n(rst_n), .want(want),
    .config_enable_n(en_n), .clock_source_sel_hi(ck_hi), .clock_source_sel_lo(ck_lo),
    .data_in(din));
  rmcfg_top i_dut (.pclk(pclk), .presetn(presetn), .config_enable_n(en_n),
    .clock_source_sel_hi(ck_hi), .clock_source_sel_lo(ck_lo), .data_in(din),
    .reset_output_n(rst_n), .data_bus_cfg(bus_cfg), .cfg(cfg), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // Compare and count
  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    cmp_count++;
    if (seen !== expv) begin
      num_errors++;
      $display("[FAIL] %s exp %h seen %h", what, expv, seen);
    end
  endtask

  // One APB transfer; the access phase lasts until pready, the watchdog bounds it
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Reset with given pins, then check capture, hold and readback
  task automatic run_case(logic en, logic [1:0] ck, logic [2:0] md, logic [1:0] sp,
                          logic dr, logic [1:0] pt);
    logic [31:0] d;
    d = 32'h0;
    {d[26], d[16+1], d[16]} = md;
    {d[25], d[24]} = sp;
    d[21] = dr;
    {d[20], d[19]} = pt;
    presetn <= 1'h0;
    want <= {en, ck, d};
    repeat (12) @(posedge pclk);
    check("rst_out_in_reset", {31'h0, rst_n}, 32'h0);
    check("bus_cfg_in_reset", {31'h0, bus_cfg}, 32'h1);
    exp = CFG_DEFAULT;
    if (!en) begin
      exp.master = (md == MODE_MASTER);
      exp.mode_raw = md;
      exp.port = pt == 2'h2 ? RMCFG_PORT_8 : pt == 2'h1 ? RMCFG_PORT_16 : RMCFG_PORT_32;
      exp.full_drive = dr;
      exp.clk = rmcfg_clk_t'(ck);
      exp.cs_count = {sp[0], sp[1]};
      exp.from_pins = 1'h1;
    end
    presetn <= 1'h1;
    repeat (RST_OUT_HOLD_CYCLES - 1) @(posedge pclk);
    #1 check("rst_out_early", {31'h0, rst_n}, 32'h0);
    @(posedge pclk);
    #1 check("rst_out_late", {31'h0, rst_n}, 32'h1);
    check("cfg", {20'h0, cfg}, {20'h0, exp});
    repeat (6) @(posedge pclk);
    check("cfg_held", {20'h0, cfg}, {20'h0, exp});
    check("bus_released", {31'h0, bus_cfg}, 32'h0);
    apb(1'h1, ADDR_CFG, 32'hFFFFFFFF);
    check("wr_err", {31'h0, err}, 32'h1);
    apb(1'h0, ADDR_CFG, 32'h0);
    check("rd_cfg", rd, {20'h0, exp});
    check("rd_cfg_err", {31'h0, err}, 32'h0);
    apb(1'h0, ADDR_STATUS, 32'h0);
    check("rd_status", rd, 32'h3);
    check("rd_status_err", {31'h0, err}, 32'h0);
    apb(1'h0, 12'h008, 32'h0);
    check("rd_unmapped_err", {31'h0, err}, 32'h1);
    $display("Case done en=%b ck=%h md=%h sp=%h dr=%b pt=%h", en, ck, md, sp, dr, pt);
  endtask

  // Verdict and end of run
  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Main sequence: defaults, every clock, split and port code, reserved modes 110 and 101
  initial begin
    run_case(1'h1, 2'h0, 3'h0, 2'h1, 1'h1, 2'h1);
    run_case(1'h0, 2'h0, 3'h7, 2'h0, 1'h0, 2'h0);
    run_case(1'h0, 2'h1, 3'h7, 2'h2, 1'h1, 2'h2);
    run_case(1'h0, 2'h2, 3'h7, 2'h1, 1'h0, 2'h1);
    run_case(1'h0, 2'h3, 3'h7, 2'h3, 1'h1, 2'h3);
    run_case(1'h0, 2'h3, 3'h6, 2'h0, 1'h0, 2'h0);
    run_case(1'h0, 2'h1, 3'h5, 2'h2, 1'h1, 2'h1);
    final_report();
  end

  // Watchdog
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
endmodule
